// ===== bench/dpc_enc_model.sv
// encoder model: one pulse on phase b counts up, on phase a down
`timescale 1ns/1ps
module dpc_enc_model
(
    input logic mclk,
    input logic [1:0] inc,
    input logic [1:0] dec,
    output logic [1:0] phase_a,
    output logic [1:0] phase_b,
    output logic [1:0] phase_z
);
    // z is never pulsed, so the z-plus-software reset stays untested here
    initial {phase_a, phase_b, phase_z} = 6'h00;
    // requests last two cycles, so every pulse is at least that wide
    always @(posedge mclk)
    begin
        phase_a <= dec;
        phase_b <= inc;
    end
endmodule

// ===== bench/dpc_top_sva.sv
// checker for the apb answers and routine requests of the counter block
`timescale 1ns/1ps
module dpc_top_sva
(
    input logic mclk,
    input logic srst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic [1:0] irq_req,
    input logic [5:0] irq_num_p1,
    input logic [15:0] irq_refresh_p1
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // read answers only; during writes prdata is free
    wire rdk = pready && !pwrite;
    wait_ready_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    mode_word_a: assert property (
        rdk && paddr == 12'h000 |-> prdata[31:16] == 16'h0000)
        else $error("port mode read too wide");
    settings_word_a: assert property (
        rdk && (paddr == 12'h004 || paddr == 12'h008) |-> prdata[31:16] == 16'h0000)
        else $error("settings read too wide");
    mirror_word_a: assert property (
        rdk && paddr >= 12'h014 && paddr <= 12'h020 |-> prdata[31:16] == 16'h0000)
        else $error("mirror read too wide");
    error_byte_a: assert property (
        rdk && paddr == 12'h024 |-> prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00)
        else $error("error code outside its byte");
    status_bits_a: assert property (
        rdk && (paddr == 12'h028 || paddr == 12'h02C) |-> prdata[31:10] == 22'h0)
        else $error("status read has stray bits");
    irq_pulse_a: assert property (irq_req[0] |=> !irq_req[0])
        else $error("routine request longer than one cycle");
    irq_num_hold_a: assert property ($changed(irq_num_p1) |-> irq_req[0])
        else $error("routine number changed without request");
    refresh_copy_a: assert property (
        pready && pwrite && paddr == 12'h00C |=> ##1 irq_refresh_p1 == $past(pwdata[15:0], 2))
        else $error("refresh copy not updated");
endmodule
bind dpc_top dpc_top_sva chk_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .irq_req(irq_req), .irq_num_p1(irq_num_p1), .irq_refresh_p1(irq_refresh_p1));

// ===== bench/dpc_top_tb.sv
// self-checking bench for the dual pulse counter block
`timescale 1ns/1ps
module dpc_top_tb;
    logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, prog_run = 0, scan_tick = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr;
    logic [1:0] pa, pb, pz, irq_req, inc = 2'h0, dec = 2'h0;
    logic [5:0] irq_num_p1, inum2;
    logic [15:0] rfr1, rfr2, rv;
    logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h024, 12'h028,
        12'h02C};
    integer miscompares = 0, checked = 0, cycles = 0, seed = 21, nirq = 0, n;
    dpc_top dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_a(pa), .phase_b(pb), .phase_z(pz), .prog_run(prog_run), .scan_tick(scan_tick),
        .irq_req(irq_req), .irq_num_p1(irq_num_p1), .irq_num_p2(inum2), .irq_refresh_p1(rfr1),
        .irq_refresh_p2(rfr2));
    dpc_enc_model enc_u (.mclk(mclk), .inc(inc), .dec(dec), .phase_a(pa), .phase_b(pb),
        .phase_z(pz));
    initial forever #4 mclk = ~mclk;
    task final_report;
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // run ceiling well above the few hundred cycles the sequence needs
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (irq_req[0] === 1'b1)
            nirq <= nirq + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked = checked + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // an edge passes before each setup, so no signal is driven twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task cmd(input logic [1:0] op, input logic [11:0] code, input logic [11:0] port);
        apb(1'b1, 12'h034, {6'h00, op, code, port});
    endtask
    task pvchk(input logic [11:0] port, input logic [31:0] e);
        cmd(2'h3, 12'h000, port);
        rd(12'h040, e, "present value");
    endtask
    task step(input int p, input logic up, input int k);
        repeat (k)
        begin
            @(posedge mclk);
            inc[p] <= up;
            dec[p] <= !up;
            repeat (2) @(posedge mclk);
            inc[p] <= 1'b0;
            dec[p] <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    task tick;
        @(posedge mclk);
        scan_tick <= 1'b1;
        @(posedge mclk);
        scan_tick <= 1'b0;
    endtask
    function automatic logic [31:0] bcd(input int v);
        logic [31:0] r;
        int m;
        m = v < 0 ? -v : v;
        r = 32'h0;
        for (int i = 0; i < 7; i++)
        begin
            r[4*i +: 4] = 4'(m % 10);
            m = m / 10;
        end
        if (v < 0)
            r[31:28] = 4'hF;
        return r;
    endfunction
    task setpv(input int v);
        logic [31:0] b;
        b = bcd(v);
        apb(1'b1, 12'h038, {16'h0000, b[15:0]});
        apb(1'b1, 12'h03C, {16'h0000, b[31:16]});
        cmd(2'h2, 12'h002, 12'h001);
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        prog_run <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(ra[i], 32'h0, "reset value");
        apb(1'b1, 12'h04C, 32'h1);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        apb(1'b1, 12'h028, 32'hFFFF);
        rd(12'h028, 32'h0, "status after write");
        apb(1'b1, 12'h000, 32'h1);
        rd(12'h000, 32'h1, "port mode");
        rv = 16'($random(seed));
        apb(1'b1, 12'h00C, {16'h0000, rv});
        repeat (2) @(posedge mclk);
        chk("refresh copy", {16'h0000, rv}, {16'h0000, rfr1});
        apb(1'b1, 12'h010, {16'h0000, ~rv});
        repeat (2) @(posedge mclk);
        chk("refresh copy 2", {16'h0000, ~rv}, {16'h0000, rfr2});
        apb(1'b1, 12'h004, 32'h2);
        apb(1'b1, 12'h008, 32'h102);
        apb(1'b1, 12'h048, 32'h5);
        n = 1 + {$random(seed)} % 8;
        step(0, 1'b1, n);
        pvchk(12'h001, bcd(n));
        step(0, 1'b0, n + 3);
        pvchk(12'h001, bcd(-3));
        tick;
        rd(12'h014, 32'h0003, "mirror low");
        rd(12'h018, 32'hF000, "mirror high");
        step(1, 1'b0, 1);
        pvchk(12'h002, bcd(4));
        step(1, 1'b1, 1);
        pvchk(12'h002, 32'h0);
        @(posedge mclk);
        prog_run <= 1'b0;
        pvchk(12'h001, 32'h0);
        cmd(2'h2, 12'h000, 12'h001);
        rd(12'h028, 32'h0, "start without table");
        setpv(3);
        apb(1'b1, 12'h100, 32'h1);
        apb(1'b1, 12'h104, bcd(5));
        // ranges two to eight sit far away so only the first one can hit
        for (int k = 2; k < 16; k++)
            apb(1'b1, 12'h100 + 12'(4 * k), bcd(1000));
        cmd(2'h1, 12'h002, 12'h001);
        rd(12'h028, 32'h0, "load only");
        cmd(2'h2, 12'h000, 12'h001);
        rd(12'h028, 32'h100, "started");
        step(0, 1'b1, 2);
        chk("requests", 32'h1, nirq);
        chk("routine", 32'h0, {26'h0, irq_num_p1});
        chk("routine 2", 32'h0, {26'h0, inum2});
        for (int m = 0; m < 4; m++)
        begin
            cmd(2'h2, 12'h001, 12'h001);
            cmd(2'h1, 12'(m), 12'h001);
            apb(1'b0, 12'h028, 32'h0);
            chk("run after load", {31'h0, m < 2}, {31'h0, rdat[8]});
        end
        cmd(2'h2, 12'h000, 12'h001);
        step(0, 1'b0, 1);
        rd(12'h028, 32'h101, "range hit");
        setpv(8388606);
        step(0, 1'b1, 2);
        pvchk(12'h001, bcd(8388607));
        apb(1'b0, 12'h028, 32'h0);
        chk("overflow flags", 32'h200, rdat & 32'h300);
        setpv(-7);
        pvchk(12'h001, 32'hF0000007);
        apb(1'b1, 12'h004, 32'h12);
        apb(1'b1, 12'h030, 32'h1);
        tick;
        tick;
        apb(1'b1, 12'h030, 32'h0);
        pvchk(12'h001, 32'h0);
        apb(1'b1, 12'h004, 32'hF);
        rd(12'h024, 32'h0300, "setup error");
        final_report;
    end
endmodule

// ===== design/dpc_top.v
// two pulse counters with target and range comparison behind an apb slave
// How it works
// - port mode 0000 counter, 0001 positioning
// - port mode takes effect only at power-up
// - positioning mode: reads only, no comparison interrupts
// - each port owns its settings word
// - zero settings: linear, z-plus-software, differential
// - refresh word per counter, zero means none
// - counting free, comparison only after explicit start
// - value cleared at power-up, run start, stop
// - mirror words per counter, refreshed each scan
// - table load names port 001 or 002
// - load modes 000..003 target/range, start or not
// - register-only load waits for start command
// - mode control stops; code 000 restarts
// - table kept until another is loaded
// - eight digit bcd, f leads negatives
// - value read returns exact live count
// - value change from two words, upper second
// - error byte 00 normal, 03 setup error
// - status bits 0..7 follow range hits
// - status bit 8 shows comparison running
// - status bit 9 shows over or underflow
// - ring wraps max to zero and back
// - linear limit holds, stops, flags, keeps table
// - up to 48 targets, match requests routine
// - software reset bit sampled once per scan
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_top
(
    input wire mclk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] phase_a,
    input wire [1:0] phase_b,
    input wire [1:0] phase_z,
    input wire prog_run,
    input wire scan_tick,
    output reg [1:0] irq_req,
    output reg [5:0] irq_num_p1,
    output reg [5:0] irq_num_p2,
    output reg [15:0] irq_refresh_p1,
    output reg [15:0] irq_refresh_p2
);

// bcd of a signed 24 bit count, leading digit F when negative
function [31:0] to_bcd;
    input [23:0] v;
    reg [23:0] m;
    reg [31:0] d;
    integer i;
    integer j;
    begin
        m = v[23] ? (~v + 24'h000001) : v;
        d = 32'h00000000;
        for (i = 0; i < 24; i = i + 1)
        begin
            for (j = 0; j < 8; j = j + 1)
                if (d[j*4 +: 4] > 4'h4)
                    d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
            d = {d[30:0], m[23]};
            m = {m[22:0], 1'b0};
        end
        if (v[23])
            d[31:28] = `DPC_BCD_NEG;
        to_bcd = d;
    end
endfunction

// signed 24 bit count from eight digit bcd
function [23:0] from_bcd;
    input [31:0] b;
    reg [23:0] m;
    integer j;
    begin
        m = 24'h000000;
        for (j = 6; j >= 0; j = j - 1)
            m = (m << 3) + (m << 1) + {20'h00000, b[j*4 +: 4]};
        from_bcd = (b[31:28] == `DPC_BCD_NEG) ? (~m + 24'h000001) : m;
    end
endfunction

// count step {down, up} from previous and present phase levels
function [1:0] step;
    input [3:0] imode;
    input a0;
    input b0;
    input a1;
    input b1;
    reg [3:0] t;
    begin
        t = {a0, b0, a1, b1};
        step = 2'b00;
        case (imode)
            `DPC_IN_DIFF:
            begin
                if (t == 4'h2 || t == 4'hB || t == 4'hD || t == 4'h4)
                    step = 2'b01;
                else if (t == 4'h1 || t == 4'h7 || t == 4'hE || t == 4'h8)
                    step = 2'b10;
            end
            `DPC_IN_PDIR:
                if (!b0 && b1)
                    step = a1 ? 2'b10 : 2'b01;
            `DPC_IN_UPDN:
                step = {!a0 && a1, !b0 && b1};
            default:
                step = 2'b00;
        endcase
        if (step == 2'b11)
            step = 2'b00;
    end
endfunction

// settings word is valid when every field holds a defined code
function set_ok;
    input [15:0] s;
    begin
        set_ok = (s[`DPC_SET_IN_LSB +: 4] <= `DPC_IN_UPDN)
            && (s[`DPC_SET_RST_LSB +: 4] <= `DPC_RST_SW)
            && (s[`DPC_SET_RNG_LSB +: 4] <= `DPC_RNG_RING);
    end
endfunction

reg [15:0] port_func_q;
reg [15:0] set_q [0:1];
reg [15:0] refr_q [0:1];
reg [16:0] ring_q [0:1];
reg [1:0] swrst_ctl_q;
reg [31:0] cmd_q;
reg cmd_go_q;
reg [15:0] val_lo_q;
reg [15:0] val_hi_q;
reg [31:0] result_q;
reg [31:0] stg_q [0:63];
reg pos_mode_q;
reg [23:0] pv_q [0:1];
reg [31:0] mirror_q [0:1];
reg [1:0] halt_q;
reg [1:0] ovf_q;
reg [1:0] run_q;
reg [1:0] loaded_q;
reg [1:0] kind_q;
reg [5:0] tcnt_q [0:1];
reg [23:0] tbl_q [0:95];
reg [7:0] rflag_q [0:1];
reg [1:0] chg_q;
reg [1:0] swrst_q;
reg [1:0] a_q;
reg [1:0] b_q;
reg [1:0] z_q;
reg run_prev_q;
reg [31:0] rd_d;
reg err_d;
reg [7:0] err_code;
reg [1:0] pvo_sel;
reg [7:0] rhit [0:1];
reg [5:0] tidx [0:1];
reg [1:0] thit;
wire acc = psel && penable && !pready;
wire wr_go = psel && penable && pready && pwrite && !pslverr;
wire tbl_sel = paddr >= `DPC_OFS_TBL_BASE && paddr <= `DPC_OFS_TBL_END;
wire [11:0] c_port = cmd_q[`DPC_CMD_PORT_LSB +: 12];
wire [11:0] c_code = cmd_q[`DPC_CMD_CODE_LSB +: 12];
wire [1:0] c_op = cmd_q[`DPC_CMD_OP_LSB +: 2];
wire [5:0] c_base = cmd_q[`DPC_CMD_BASE_LSB +: 6];
wire c_pv = c_port == `DPC_PORT2;
wire c_valid = c_port == `DPC_PORT1 || c_port == `DPC_PORT2;
wire run_edge = prog_run != run_prev_q;
integer p;
integer i;
// own loop indices so the compare network shares no variable with the clocked block
integer cp;
integer ci;

// setup error when any settings field is undefined
always @*
begin
    err_code = `DPC_ERR_NONE;
    if (port_func_q > `DPC_PMODE_POSITION || !set_ok(set_q[0]) || !set_ok(set_q[1]))
        err_code = `DPC_ERR_SETUP;
end

// comparison of the live count against the registered table
always @*
begin
    for (cp = 0; cp < 2; cp = cp + 1)
    begin
        rhit[cp] = 8'h00;
        tidx[cp] = 6'd0;
        thit[cp] = 1'b0;
        for (ci = 0; ci < `DPC_NRANGE; ci = ci + 1)
            rhit[cp][ci] = kind_q[cp] && $signed(pv_q[cp]) >= $signed(tbl_q[cp*48 + 2*ci])
                && $signed(pv_q[cp]) <= $signed(tbl_q[cp*48 + 2*ci + 1]);
        for (ci = 47; ci >= 0; ci = ci - 1)
            if (!kind_q[cp] && ci < tcnt_q[cp] && pv_q[cp] == tbl_q[cp*48 + ci])
            begin
                thit[cp] = 1'b1;
                tidx[cp] = ci[5:0];
            end
    end
end

// apb read mux and unmapped detect
always @*
begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    pvo_sel = 2'b00;
    if (tbl_sel)
        rd_d = stg_q[paddr[7:2]];
    else
        case (paddr)
            `DPC_OFS_PORT_FUNC: rd_d = {16'h0000, port_func_q};
            `DPC_OFS_P1_SET: rd_d = {16'h0000, set_q[0]};
            `DPC_OFS_P2_SET: rd_d = {16'h0000, set_q[1]};
            `DPC_OFS_C1_REFR: rd_d = {16'h0000, refr_q[0]};
            `DPC_OFS_C2_REFR: rd_d = {16'h0000, refr_q[1]};
            `DPC_OFS_C1_LO: rd_d = {16'h0000, mirror_q[0][15:0]};
            `DPC_OFS_C1_HI: rd_d = {16'h0000, mirror_q[0][31:16]};
            `DPC_OFS_C2_LO: rd_d = {16'h0000, mirror_q[1][15:0]};
            `DPC_OFS_C2_HI: rd_d = {16'h0000, mirror_q[1][31:16]};
            `DPC_OFS_BRD_ERR: rd_d = {16'h0000, err_code, 8'h00};
            `DPC_OFS_C1_STAT: rd_d = {22'h000000, ovf_q[0], run_q[0], rflag_q[0]};
            `DPC_OFS_C2_STAT: rd_d = {22'h000000, ovf_q[1], run_q[1], rflag_q[1]};
            `DPC_OFS_CTRL: rd_d = {30'h00000000, swrst_ctl_q};
            `DPC_OFS_CMD: rd_d = cmd_q;
            `DPC_OFS_VAL_LO: rd_d = {16'h0000, val_lo_q};
            `DPC_OFS_VAL_HI: rd_d = {16'h0000, val_hi_q};
            `DPC_OFS_RESULT: rd_d = result_q;
            `DPC_OFS_RING1: rd_d = {15'h0000, ring_q[0]};
            `DPC_OFS_RING2: rd_d = {15'h0000, ring_q[1]};
            default: err_d = 1'b1;
        endcase
end

// apb slave: one wait cycle so data and pready leave flip-flops
always @(posedge mclk)
begin
    if (srst)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else if (acc)
    begin
        pready <= 1'b1;
        pslverr <= err_d;
        prdata <= pwrite ? 32'h00000000 : rd_d;
    end
    else
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
end

// software registers; a command write raises a one-cycle go strobe
always @(posedge mclk)
begin
    cmd_go_q <= 1'b0;
    if (srst)
    begin
        port_func_q <= `DPC_RST_WORD16;
        set_q[0] <= `DPC_RST_WORD16;
        set_q[1] <= `DPC_RST_WORD16;
        refr_q[0] <= `DPC_RST_WORD16;
        refr_q[1] <= `DPC_RST_WORD16;
        ring_q[0] <= `DPC_RST_RING;
        ring_q[1] <= `DPC_RST_RING;
        swrst_ctl_q <= 2'b00;
        cmd_q <= 32'h00000000;
        val_lo_q <= `DPC_RST_WORD16;
        val_hi_q <= `DPC_RST_WORD16;
    end
    else if (wr_go)
    begin
        if (tbl_sel)
            stg_q[paddr[7:2]] <= pwdata;
        else
            case (paddr)
                `DPC_OFS_PORT_FUNC: port_func_q <= pwdata[15:0];
                `DPC_OFS_P1_SET: set_q[0] <= pwdata[15:0];
                `DPC_OFS_P2_SET: set_q[1] <= pwdata[15:0];
                `DPC_OFS_C1_REFR: refr_q[0] <= pwdata[15:0];
                `DPC_OFS_C2_REFR: refr_q[1] <= pwdata[15:0];
                `DPC_OFS_CTRL: swrst_ctl_q <= pwdata[1:0];
                `DPC_OFS_VAL_LO: val_lo_q <= pwdata[15:0];
                `DPC_OFS_VAL_HI: val_hi_q <= pwdata[15:0];
                `DPC_OFS_RING1: ring_q[0] <= pwdata[16:0];
                `DPC_OFS_RING2: ring_q[1] <= pwdata[16:0];
                `DPC_OFS_CMD:
                begin
                    cmd_q <= pwdata;
                    cmd_go_q <= 1'b1;
                end
                default: cmd_go_q <= 1'b0;
            endcase
    end
end

// port mode latched only while reset is held, i.e. at power-up
always @(posedge mclk)
begin
    if (srst)
        pos_mode_q <= port_func_q == `DPC_PMODE_POSITION;
end

// counters, comparison engine and command execution
always @(posedge mclk)
begin
    a_q <= phase_a;
    b_q <= phase_b;
    z_q <= phase_z;
    run_prev_q <= prog_run;
    irq_req <= 2'b00;
    chg_q <= 2'b00;
    if (srst)
    begin
        run_prev_q <= 1'b0;
        halt_q <= 2'b00;
        ovf_q <= 2'b00;
        run_q <= 2'b00;
        loaded_q <= 2'b00;
        kind_q <= 2'b00;
        swrst_q <= 2'b00;
        result_q <= 32'h00000000;
        irq_num_p1 <= 6'd0;
        irq_num_p2 <= 6'd0;
        irq_refresh_p1 <= `DPC_RST_WORD16;
        irq_refresh_p2 <= `DPC_RST_WORD16;
        for (p = 0; p < 2; p = p + 1)
        begin
            pv_q[p] <= 24'h000000;
            mirror_q[p] <= 32'h00000000;
            tcnt_q[p] <= 6'd0;
            rflag_q[p] <= 8'h00;
        end
    end
    else
    begin
        if (scan_tick)
            swrst_q <= swrst_ctl_q;
        for (p = 0; p < 2; p = p + 1)
        begin
            if (scan_tick)
                mirror_q[p] <= to_bcd(pv_q[p]);
            if (run_edge)
            begin
                pv_q[p] <= 24'h000000;
                halt_q[p] <= 1'b0;
                ovf_q[p] <= 1'b0;
            end
            else if (swrst_q[p] && ((set_q[p][`DPC_SET_RST_LSB +: 4] == `DPC_RST_SW && scan_tick)
                || (set_q[p][`DPC_SET_RST_LSB +: 4] == `DPC_RST_ZSW && !z_q[p] && phase_z[p])))
            begin
                pv_q[p] <= 24'h000000;
                halt_q[p] <= 1'b0;
                ovf_q[p] <= 1'b0;
                chg_q[p] <= 1'b1;
            end
            else if (!halt_q[p] && set_ok(set_q[p]))
            begin
                if (set_q[p][`DPC_SET_RNG_LSB +: 4] == `DPC_RNG_RING)
                begin
                    if (step(set_q[p][3:0], a_q[p], b_q[p], phase_a[p], phase_b[p]) == 2'b01)
                    begin
                        pv_q[p] <= (pv_q[p] >= {7'h00, ring_q[p]} - 24'h000001) ? 24'h000000
                            : pv_q[p] + 24'h000001;
                        chg_q[p] <= 1'b1;
                    end
                    else if (step(set_q[p][3:0], a_q[p], b_q[p], phase_a[p], phase_b[p]) == 2'b10)
                    begin
                        pv_q[p] <= (pv_q[p] == 24'h000000) ? {7'h00, ring_q[p]} - 24'h000001
                            : pv_q[p] - 24'h000001;
                        chg_q[p] <= 1'b1;
                    end
                end
                else if (step(set_q[p][3:0], a_q[p], b_q[p], phase_a[p], phase_b[p]) == 2'b01)
                begin
                    if (pv_q[p] == `DPC_LIN_MAX)
                    begin
                        halt_q[p] <= 1'b1;
                        ovf_q[p] <= 1'b1;
                        run_q[p] <= 1'b0;
                    end
                    else
                    begin
                        pv_q[p] <= pv_q[p] + 24'h000001;
                        chg_q[p] <= 1'b1;
                    end
                end
                else if (step(set_q[p][3:0], a_q[p], b_q[p], phase_a[p], phase_b[p]) == 2'b10)
                begin
                    if (pv_q[p] == `DPC_LIN_MIN)
                    begin
                        halt_q[p] <= 1'b1;
                        ovf_q[p] <= 1'b1;
                        run_q[p] <= 1'b0;
                    end
                    else
                    begin
                        pv_q[p] <= pv_q[p] - 24'h000001;
                        chg_q[p] <= 1'b1;
                    end
                end
            end
            // range flags live only while comparing; entering a range requests its routine
            rflag_q[p] <= run_q[p] ? rhit[p] : 8'h00;
            if (run_q[p] && !pos_mode_q)
            begin
                for (i = `DPC_NRANGE - 1; i >= 0; i = i - 1)
                    if (rhit[p][i] && !rflag_q[p][i])
                    begin
                        irq_req[p] <= 1'b1;
                        if (p == 0)
                            irq_num_p1 <= i[5:0];
                        else
                            irq_num_p2 <= i[5:0];
                    end
                if (chg_q[p] && thit[p])
                begin
                    irq_req[p] <= 1'b1;
                    if (p == 0)
                        irq_num_p1 <= tidx[p];
                    else
                        irq_num_p2 <= tidx[p];
                end
            end
        end
        irq_refresh_p1 <= refr_q[0];
        irq_refresh_p2 <= refr_q[1];
        // commands; invalid port codes are dropped
        if (cmd_go_q && c_valid)
            case (c_op)
                `DPC_OP_TABLE_LOAD:
                    if (!pos_mode_q && c_code <= `DPC_TL_RNG_ONLY)
                    begin
                        loaded_q[c_pv] <= 1'b1;
                        kind_q[c_pv] <= c_code[0];
                        tcnt_q[c_pv] <= (stg_q[c_base][5:0] > `DPC_TGT_MAX) ? `DPC_TGT_MAX
                            : stg_q[c_base][5:0];
                        run_q[c_pv] <= !c_code[1] && !halt_q[c_pv];
                        for (i = 0; i < 48; i = i + 1)
                            tbl_q[(c_pv ? 48 : 0) + i] <= c_code[0]
                                ? from_bcd(stg_q[(c_base + i) & 63])
                                : from_bcd(stg_q[(c_base + 1 + i) & 63]);
                    end
                `DPC_OP_MODE_CTRL:
                    if (c_code == `DPC_MC_START && !pos_mode_q)
                        run_q[c_pv] <= loaded_q[c_pv] && !halt_q[c_pv];
                    else if (c_code == `DPC_MC_STOP && !pos_mode_q)
                        run_q[c_pv] <= 1'b0;
                    else if (c_code == `DPC_MC_CHANGE_PV)
                    begin
                        pv_q[c_pv] <= from_bcd({val_hi_q, val_lo_q});
                        halt_q[c_pv] <= 1'b0;
                        chg_q[c_pv] <= 1'b1;
                    end
                `DPC_OP_VALUE_READ:
                    if (c_code == `DPC_VR_STATUS)
                        result_q <= {30'h00000000, ovf_q[c_pv], run_q[c_pv]};
                    else
                        result_q <= to_bcd(pv_q[c_pv]);
                default:
                    result_q <= result_q;
            endcase
    end
end

endmodule

// ===== inc/dpc_consts.vh
// constants of the dual pulse counter with compare engine
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH
// register byte offsets
`define DPC_OFS_PORT_FUNC 12'h000
`define DPC_OFS_P1_SET 12'h004
`define DPC_OFS_P2_SET 12'h008
`define DPC_OFS_C1_REFR 12'h00C
`define DPC_OFS_C2_REFR 12'h010
`define DPC_OFS_C1_LO 12'h014
`define DPC_OFS_C1_HI 12'h018
`define DPC_OFS_C2_LO 12'h01C
`define DPC_OFS_C2_HI 12'h020
`define DPC_OFS_BRD_ERR 12'h024
`define DPC_OFS_C1_STAT 12'h028
`define DPC_OFS_C2_STAT 12'h02C
`define DPC_OFS_CTRL 12'h030
`define DPC_OFS_CMD 12'h034
`define DPC_OFS_VAL_LO 12'h038
`define DPC_OFS_VAL_HI 12'h03C
`define DPC_OFS_RESULT 12'h040
`define DPC_OFS_RING1 12'h044
`define DPC_OFS_RING2 12'h048
`define DPC_OFS_TBL_BASE 12'h100
`define DPC_OFS_TBL_END 12'h1FC
// reset values
`define DPC_RST_WORD16 16'h0000
`define DPC_RST_RING 17'h0FDE8
// port mode word values
`define DPC_PMODE_COUNTER 16'h0000
`define DPC_PMODE_POSITION 16'h0001
// settings word fields
`define DPC_SET_IN_LSB 0
`define DPC_SET_RST_LSB 4
`define DPC_SET_RNG_LSB 8
`define DPC_IN_DIFF 4'h0
`define DPC_IN_PDIR 4'h1
`define DPC_IN_UPDN 4'h2
`define DPC_RST_ZSW 4'h0
`define DPC_RST_SW 4'h1
`define DPC_RNG_LIN 4'h0
`define DPC_RNG_RING 4'h1
// command word fields and codes
`define DPC_CMD_PORT_LSB 0
`define DPC_CMD_CODE_LSB 12
`define DPC_CMD_OP_LSB 24
`define DPC_CMD_BASE_LSB 26
`define DPC_OP_TABLE_LOAD 2'h1
`define DPC_OP_MODE_CTRL 2'h2
`define DPC_OP_VALUE_READ 2'h3
`define DPC_PORT1 12'h001
`define DPC_PORT2 12'h002
`define DPC_TL_TGT_START 12'h000
`define DPC_TL_RNG_START 12'h001
`define DPC_TL_TGT_ONLY 12'h002
`define DPC_TL_RNG_ONLY 12'h003
`define DPC_MC_START 12'h000
`define DPC_MC_STOP 12'h001
`define DPC_MC_CHANGE_PV 12'h002
`define DPC_VR_PV 12'h000
`define DPC_VR_STATUS 12'h001
// status and error fields
`define DPC_ST_RUN_BIT 8
`define DPC_ST_OVF_BIT 9
`define DPC_ERR_LSB 8
`define DPC_ERR_NONE 8'h00
`define DPC_ERR_SETUP 8'h03
// counting limits and table sizes
`define DPC_LIN_MAX 24'h7FFFFF
`define DPC_LIN_MIN 24'h800000
`define DPC_RING_LIMIT 17'h0FDE8
`define DPC_TGT_MAX 6'd48
`define DPC_NRANGE 8
`define DPC_BCD_NEG 4'hF
`endif
